// [design/adc_control_register_decode.sv]
module adc_control_register_decode (
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // Serial write pins
  input  wire logic        sclk_pin,
  input  wire logic        din_pin,
  input  wire logic        frame_n_pin,
  // Read side and sleep pin
  input  wire logic        read_cycle_done,
  input  wire logic        sleep_n_pin,
  // Input routing
  output logic             input_pairing_select,
  output logic [2:0]       pos_input_index,
  output logic [3:0]       neg_input_index,
  // Power, read target, interface mode
  output logic [1:0]       power_mgmt,
  output logic [2:0]       power_mode_select,
  output logic [1:0]       read_target,
  output logic             interface_mode1,
  output logic             din_drive_allowed,
  // Conversion engine
  output logic             conv_start,
  input  wire logic        conv_done,
  // Calibration engine
  output logic             cal_step_req,
  output logic [2:0]       cal_step,
  input  wire logic        cal_step_done,
  output logic [1:0]       cal_reg_addr,
  // Other register writes
  output logic             test_write,
  output logic             cal_reg_write,
  output logic [13:0]      write_data,
  // State
  output logic             busy,
  output logic [15:0]      status_word
);

  typedef struct packed {
    logic [13:0]              cfg;
    adc_cfg_pkg::seq_state_t  state;
    logic                     cal_kind;
    logic [1:0]               cal_sel;
    logic [1:0]               cal_idx;
    adc_cfg_pkg::cal_step_t   step;
    logic                     step_req;
    logic                     conv_start;
    logic                     test_write;
    logic                     cal_reg_write;
    logic [13:0]              write_data;
    logic                     sleep_meta;
    logic                     sleep_sync;
    logic [2:0]               pos;
    logic [3:0]               neg;
    logic [2:0]               power_mode;
    logic                     busy;
    logic [15:0]              status;
  } ctl_state_t;

  localparam ctl_state_t CTL_RESET = '{
    cfg: adc_cfg_pkg::CFG_RESET, state: adc_cfg_pkg::SEQ_IDLE,
    cal_kind: 1'b0, cal_sel: 2'h0, cal_idx: 2'h0, step: adc_cfg_pkg::STEP_NONE,
    step_req: 1'b0, conv_start: 1'b0, test_write: 1'b0, cal_reg_write: 1'b0,
    write_data: 14'h0000, sleep_meta: 1'b1, sleep_sync: 1'b1,
    pos: 3'h0, neg: 4'h1, power_mode: 3'h0, busy: 1'b0, status: 16'h0000};

  ctl_state_t st;
  ctl_state_t next_st;
  logic       rx_valid;
  logic [15:0] rx_word;
  logic       wr_cfg;

  // Channel index 0 stands for the first analog input, 7 for the eighth.
  function automatic logic [2:0] pos_of(input logic [2:0] ch);
    pos_of = {ch[1:0], ch[2]};
  endfunction : pos_of

  function automatic logic [3:0] neg_of(input logic pair, input logic [2:0] ch);
    neg_of = pair ? adc_cfg_pkg::NEG_GROUND : {1'b0, ch[1:0], ~ch[2]};
  endfunction : neg_of

  function automatic logic [1:0] cal_len(input logic [1:0] sel);
    cal_len = (sel == 2'h0) ? 2'h3 : (sel == 2'h1) ? 2'h2 : 2'h1;
  endfunction : cal_len

  function automatic adc_cfg_pkg::cal_step_t cal_step_of(input logic       kind,
                                                         input logic [1:0] sel,
                                                         input logic [1:0] idx);
    adc_cfg_pkg::cal_step_t gain;
    adc_cfg_pkg::cal_step_t offs;
    gain = kind ? adc_cfg_pkg::STEP_SYS_GAIN : adc_cfg_pkg::STEP_INT_GAIN;
    offs = kind ? adc_cfg_pkg::STEP_SYS_OFFSET : adc_cfg_pkg::STEP_INT_OFFSET;
    case (sel)
      2'h0: begin
        cal_step_of = (idx == 2'h0) ? adc_cfg_pkg::STEP_DAC : (idx == 2'h1) ? gain : offs;
      end
      2'h1: begin
        cal_step_of = (idx == 2'h0) ? gain : offs;
      end
      2'h2: begin
        cal_step_of = offs;
      end
      default: begin
        cal_step_of = gain;
      end
    endcase
  endfunction : cal_step_of

  serial_word_receiver u_rx (
    .mclk        (mclk),
    .rstn        (rstn),
    .clk_en      (clk_en),
    .sclk_pin    (sclk_pin),
    .din_pin     (din_pin),
    .frame_n_pin (frame_n_pin),
    .word_valid  (rx_valid),
    .word        (rx_word)
  );

  // [RL2] Address 11 decode.
  assign wr_cfg = rx_valid && (rx_word[adc_cfg_pkg::ADDR_MSB:adc_cfg_pkg::ADDR_LSB] ==
                               adc_cfg_pkg::ADDR_CONFIG);

  always_comb begin
    next_st               = st;
    next_st.sleep_meta    = sleep_n_pin;
    next_st.sleep_sync    = st.sleep_meta;
    next_st.step_req      = 1'b0;
    next_st.conv_start    = 1'b0;
    next_st.test_write    = 1'b0;
    next_st.cal_reg_write = 1'b0;
    // [RL21] Other address codes.
    if (rx_valid) begin
      next_st.write_data = rx_word[13:0];
      case (rx_word[adc_cfg_pkg::ADDR_MSB:adc_cfg_pkg::ADDR_LSB])
        adc_cfg_pkg::ADDR_TEST:   next_st.test_write = 1'b1;
        adc_cfg_pkg::ADDR_CALREG: next_st.cal_reg_write = 1'b1;
        default:                  next_st.test_write = 1'b0;
      endcase
    end
    // [RL11] Read clears mode.
    if (read_cycle_done) begin
      next_st.cfg[adc_cfg_pkg::BIT_IFMODE] = 1'b0;
    end
    // A write in the same cycle as a read end keeps the newly written mode bit.
    if (wr_cfg) begin
      next_st.cfg[13:5] = rx_word[13:5];
      next_st.cfg[3:1]  = rx_word[3:1];
    end
    case (st.state)
      adc_cfg_pkg::SEQ_IDLE: begin
        // [RL14] Calibration start accepted.
        if (wr_cfg && rx_word[adc_cfg_pkg::BIT_CALSTART]) begin
          next_st.cfg[adc_cfg_pkg::BIT_CALSTART] = 1'b1;
          next_st.cal_kind = rx_word[adc_cfg_pkg::BIT_CALKIND];
          next_st.cal_sel  = rx_word[adc_cfg_pkg::CALSEL_MSB:adc_cfg_pkg::CALSEL_LSB];
          next_st.cal_idx  = 2'h0;
          next_st.state    = adc_cfg_pkg::SEQ_CAL_REQ;
        // [RL12] Conversion start accepted.
        end else if (wr_cfg && rx_word[adc_cfg_pkg::BIT_CONV]) begin
          next_st.cfg[adc_cfg_pkg::BIT_CONV] = 1'b1;
          next_st.conv_start = 1'b1;
          next_st.state      = adc_cfg_pkg::SEQ_CONV;
        end
      end
      adc_cfg_pkg::SEQ_CONV: begin
        // [RL12] Conversion bit self-clears.
        if (conv_done) begin
          next_st.cfg[adc_cfg_pkg::BIT_CONV] = 1'b0;
          next_st.state = adc_cfg_pkg::SEQ_IDLE;
        end
      end
      adc_cfg_pkg::SEQ_CAL_REQ: begin
        // [RL16] [RL17] [RL18] [RL19] Step order table.
        next_st.step     = cal_step_of(st.cal_kind, st.cal_sel, st.cal_idx);
        next_st.step_req = 1'b1;
        next_st.state    = adc_cfg_pkg::SEQ_CAL_WAIT;
      end
      adc_cfg_pkg::SEQ_CAL_WAIT: begin
        if (cal_step_done) begin
          // [RL14] Start bit self-clears.
          if (st.cal_idx + 2'h1 == cal_len(st.cal_sel)) begin
            next_st.cfg[adc_cfg_pkg::BIT_CALSTART] = 1'b0;
            next_st.step  = adc_cfg_pkg::STEP_NONE;
            next_st.state = adc_cfg_pkg::SEQ_IDLE;
          end else begin
            next_st.cal_idx = st.cal_idx + 2'h1;
            next_st.state   = adc_cfg_pkg::SEQ_CAL_REQ;
          end
        end
      end
      default: begin
        next_st.state = adc_cfg_pkg::SEQ_IDLE;
      end
    endcase
    // [RL22] Busy tracks sequencer.
    next_st.busy = (next_st.state != adc_cfg_pkg::SEQ_IDLE);
    // [RL5] [RL6] [RL7] Channel routing.
    next_st.pos = pos_of(next_st.cfg[adc_cfg_pkg::CH_MSB:adc_cfg_pkg::CH_LSB]);
    next_st.neg = neg_of(next_st.cfg[adc_cfg_pkg::BIT_PAIRING],
                         next_st.cfg[adc_cfg_pkg::CH_MSB:adc_cfg_pkg::CH_LSB]);
    // [RL8] Power with sleep.
    next_st.power_mode = {~next_st.sleep_sync,
                          next_st.cfg[adc_cfg_pkg::PM_MSB:adc_cfg_pkg::PM_LSB]};
    // [RL1] Status view only.
    next_st.status = {1'b0, next_st.busy, next_st.cfg[13:8], adc_cfg_pkg::RD_STATUS,
                      next_st.cfg[adc_cfg_pkg::BIT_IFMODE], 1'b0, next_st.cfg[3:0]};
  end

  // [RL3] Clear at reset.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st <= CTL_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // [RL4] Pairing bit out.
  assign input_pairing_select = st.cfg[adc_cfg_pkg::BIT_PAIRING];
  assign pos_input_index      = st.pos;
  assign neg_input_index      = st.neg;
  assign power_mgmt           = st.cfg[adc_cfg_pkg::PM_MSB:adc_cfg_pkg::PM_LSB];
  assign power_mode_select    = st.power_mode;
  // [RL9] Read target select.
  assign read_target          = st.cfg[adc_cfg_pkg::RD_MSB:adc_cfg_pkg::RD_LSB];
  // [RL10] Interface mode 1.
  assign interface_mode1      = st.cfg[adc_cfg_pkg::BIT_IFMODE];
  assign din_drive_allowed    = st.cfg[adc_cfg_pkg::BIT_IFMODE];
  assign conv_start           = st.conv_start;
  assign cal_step_req         = st.step_req;
  assign cal_step             = st.step;
  // [RL13] [RL15] Coefficient addressing.
  assign cal_reg_addr         = st.cfg[adc_cfg_pkg::BIT_CALSTART] ? 2'h0 :
                                st.cfg[adc_cfg_pkg::CALSEL_MSB:adc_cfg_pkg::CALSEL_LSB];
  assign test_write           = st.test_write;
  assign cal_reg_write        = st.cal_reg_write;
  assign write_data           = st.write_data;
  assign busy                 = st.busy;
  assign status_word          = st.status;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn || !clk_en);

  chk_reset_clear: assert property (disable iff (1'b0) !rstn |=> st.cfg == 14'h0000) // RL3
    else $error("configuration not cleared by reset");
  chk_cfg_load_word: assert property (wr_cfg |=> st.cfg[13:5] == $past(rx_word[13:5])) // RL2
    else $error("configuration write not stored");
  chk_other_addr_ignored: assert property (rx_valid && !wr_cfg && !read_cycle_done
                                           |=> $stable(st.cfg)) // RL21
    else $error("non-configuration write changed configuration");
  chk_mode_read_clear: assert property (read_cycle_done && !wr_cfg |=> !interface_mode1) // RL11
    else $error("interface mode not cleared after read");
  chk_conv_busy_span: assert property (conv_start || st.state == adc_cfg_pkg::SEQ_CONV
                                       |-> busy && st.cfg[adc_cfg_pkg::BIT_CONV]) // RL22
    else $error("conversion start without busy");
  chk_conv_finish: assert property (st.state == adc_cfg_pkg::SEQ_CONV && conv_done
                                    |=> !st.cfg[4] && !busy) // RL12
    else $error("conversion bit not cleared at end");
  chk_diff_pairing: assert property (!input_pairing_select
                                     |-> neg_input_index == {1'b0, pos_input_index ^ 3'h1}) // RL6
    else $error("pseudo-differential pair wrong");
  chk_single_ground: assert property (input_pairing_select
                                      |-> neg_input_index == 4'h8) // RL7
    else $error("single-ended negative not ground");
  chk_full_cal_first: assert property (st.state == adc_cfg_pkg::SEQ_IDLE && wr_cfg
                                       && rx_word[0] && rx_word[2:1] == 2'h0
                                       |=> ##1 cal_step_req && cal_step == 3'h1) // RL16
    else $error("full calibration does not begin with DAC");
  chk_cal_addr_view: assert property (!st.cfg[0] |-> cal_reg_addr == st.cfg[2:1]) // RL15
    else $error("coefficient address not from select bits");
  // The status view is all zero while held in reset, so the first edge after release is skipped.
  chk_status_view: assert property ($past(rstn) |-> status_word[7:6] == 2'h3
                                    && status_word[14] == busy) // RL9
    else $error("status word fields wrong");

  cov_conversion: cover property (conv_start ##[1:200] conv_done);
  cov_full_self_cal: cover property (cal_step_req && cal_step == 3'h1 && !st.cal_kind);
  cov_system_cal: cover property (cal_step_req && cal_step == 3'h5);
  cov_test_write: cover property (test_write);

endmodule : adc_control_register_decode

// [design/adc_cfg_pkg.sv]
// Overview of operation
// [RL1] Write-only fourteen-bit configuration register.
// [RL2] Address bits 11 route data into it.
// [RL3] Power-up clears every configuration bit.
// [RL4] Bit 13 picks pseudo-differential or single-ended.
// [RL5] Bits 12..10 pick the conversion channel.
// [RL6] Differential codes pair inputs, upper codes swap.
// [RL7] Single-ended codes pick odd then even inputs.
// [RL8] Power bits with sleep pin pick power-down.
// [RL9] Bits 7..6 choose the read target.
// [RL10] Bit 5 one enables interface mode 1.
// [RL11] Mode bit clears after every read cycle; a configuration write ending in the same cycle loads the written bit instead.
// [RL12] Conversion-start bit launches one, self-clears.
// [RL13] Bit 3 chooses self or system calibration.
// [RL14] Calibration start runs selected type, self-clears.
// [RL15] Without start, select bits address coefficient registers.
// [RL16] Full self calibration: DAC, gain, offset.
// [RL17] Self codes: gain+offset, offset, gain.
// [RL18] Full system calibration: DAC, gain, offset.
// [RL19] System codes: gain+offset, offset, gain.
// [RL20] Sixteen-bit word latched only when complete.
// [RL21] Address 00 ignored, 01 test, 10 calibration.
// [RL22] Busy from accepted start until completion.
package adc_cfg_pkg;

  localparam int           WORD_BITS     = 16;
  localparam int           CFG_BITS      = 14;
  localparam logic [4:0]   LAST_BIT_IDX  = 5'h0F;

  localparam logic [1:0]   ADDR_NONE     = 2'h0;
  localparam logic [1:0]   ADDR_TEST     = 2'h1;
  localparam logic [1:0]   ADDR_CALREG   = 2'h2;
  localparam logic [1:0]   ADDR_CONFIG   = 2'h3;
  localparam int           ADDR_MSB      = 15;
  localparam int           ADDR_LSB      = 14;

  localparam int           BIT_PAIRING   = 13;
  localparam int           CH_MSB        = 12;
  localparam int           CH_LSB        = 10;
  localparam int           PM_MSB        = 9;
  localparam int           PM_LSB        = 8;
  localparam int           RD_MSB        = 7;
  localparam int           RD_LSB        = 6;
  localparam int           BIT_IFMODE    = 5;
  localparam int           BIT_CONV      = 4;
  localparam int           BIT_CALKIND   = 3;
  localparam int           CALSEL_MSB    = 2;
  localparam int           CALSEL_LSB    = 1;
  localparam int           BIT_CALSTART  = 0;

  localparam logic [13:0]  CFG_RESET     = 14'h0000;
  localparam logic [1:0]   RD_STATUS     = 2'h3;
  localparam logic [3:0]   NEG_GROUND    = 4'h8;

  typedef enum logic [1:0] {
    SEQ_IDLE     = 2'b00,
    SEQ_CAL_REQ  = 2'b01,
    SEQ_CAL_WAIT = 2'b11,
    SEQ_CONV     = 2'b10
  } seq_state_t;

  typedef enum logic [2:0] {
    STEP_NONE       = 3'h0,
    STEP_DAC        = 3'h1,
    STEP_INT_GAIN   = 3'h2,
    STEP_INT_OFFSET = 3'h3,
    STEP_SYS_GAIN   = 3'h4,
    STEP_SYS_OFFSET = 3'h5
  } cal_step_t;

endpackage : adc_cfg_pkg

// [design/serial_word_receiver.sv]
module serial_word_receiver (
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // Serial pins
  input  wire logic        sclk_pin,
  input  wire logic        din_pin,
  input  wire logic        frame_n_pin,
  // Received word
  output logic             word_valid,
  output logic [15:0]      word
);

  typedef struct packed {
    logic        sclk_meta;
    logic        sclk_sync;
    logic        sclk_prev;
    logic        din_meta;
    logic        din_sync;
    logic        frame_meta;
    logic        frame_sync;
    logic [15:0] shift;
    logic [4:0]  count;
    logic [15:0] word;
    logic        valid;
  } rx_state_t;

  localparam rx_state_t RX_RESET = '{
    sclk_meta: 1'b0, sclk_sync: 1'b0, sclk_prev: 1'b0,
    din_meta: 1'b0, din_sync: 1'b0,
    frame_meta: 1'b1, frame_sync: 1'b1,
    shift: 16'h0000, count: 5'h00, word: 16'h0000, valid: 1'b0};

  rx_state_t st;
  rx_state_t next_st;

  always_comb begin
    next_st            = st;
    next_st.sclk_meta  = sclk_pin;
    next_st.sclk_sync  = st.sclk_meta;
    next_st.sclk_prev  = st.sclk_sync;
    next_st.din_meta   = din_pin;
    next_st.din_sync   = st.din_meta;
    next_st.frame_meta = frame_n_pin;
    next_st.frame_sync = st.frame_meta;
    next_st.valid      = 1'b0;
    // [RL20] Partial words dropped.
    if (st.frame_sync) begin
      next_st.count = 5'h00;
    end else if (st.sclk_sync && !st.sclk_prev) begin
      next_st.shift = {st.shift[14:0], st.din_sync};
      if (st.count == adc_cfg_pkg::LAST_BIT_IDX) begin
        next_st.word  = {st.shift[14:0], st.din_sync};
        next_st.valid = 1'b1;
        next_st.count = 5'h00;
      end else begin
        next_st.count = st.count + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st <= RX_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign word_valid = st.valid;
  assign word       = st.word;

endmodule : serial_word_receiver

// [verification/host_serial_model.sv]
module host_serial_model (
  // Clock
  input  wire logic mclk,
  // Serial pins
  output logic      sclk_pin,
  output logic      din_pin,
  output logic      frame_n_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sclk_pin    = 1'b0;
    din_pin     = 1'b1;
    frame_n_pin = 1'b1;
  end

  task automatic send(input logic [15:0] w, input int n);
    @(posedge mclk);
    frame_n_pin <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      din_pin <= w[i];
      repeat (3) @(posedge mclk);
      sclk_pin <= 1'b1;
      repeat (3) @(posedge mclk);
      sclk_pin <= 1'b0;
    end
    repeat (3) @(posedge mclk);
    frame_n_pin <= 1'b1;
    // A released line must not keep showing the last bit as if still valid.
    din_pin <= ~w[16 - n];
  endtask : send
endmodule : host_serial_model

// [verification/adc_control_register_decode_bench.sv]
module adc_control_register_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk, rstn, clk_en, read_cycle_done, sleep_n_pin;
  logic        conv_done, cal_step_done, sclk_pin, din_pin, frame_n_pin;
  logic        input_pairing_select, interface_mode1, din_drive_allowed;
  logic        conv_start, cal_step_req, test_write, cal_reg_write, busy;
  logic [2:0]  pos_input_index, power_mode_select, cal_step;
  logic [3:0]  neg_input_index;
  logic [1:0]  power_mgmt, read_target, cal_reg_addr;
  logic [13:0] write_data;
  logic [15:0] status_word;
  logic [2:0]  steps[$];
  int          mismatches, cmp_count, n_test, n_calw, n_conv;
  int          conv_wait, step_wait;

  // Expected {pairing, positive, negative} for channel codes 0..7, then single-ended.
  localparam logic [7:0] ROWS [16] = '{8'h01, 8'h23, 8'h45, 8'h67, 8'h10, 8'h32, 8'h54, 8'h76,
                                       8'h88, 8'hA8, 8'hC8, 8'hE8, 8'h98, 8'hB8, 8'hD8, 8'hF8};

  host_serial_model host (.mclk, .sclk_pin, .din_pin, .frame_n_pin);

  adc_control_register_decode uut (
    .mclk, .rstn, .clk_en, .sclk_pin, .din_pin, .frame_n_pin,
    .read_cycle_done, .sleep_n_pin, .input_pairing_select,
    .pos_input_index, .neg_input_index, .power_mgmt, .power_mode_select,
    .read_target, .interface_mode1, .din_drive_allowed, .conv_start,
    .conv_done, .cal_step_req, .cal_step, .cal_step_done, .cal_reg_addr,
    .test_write, .cal_reg_write, .write_data, .busy, .status_word
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Engine stand-in: slow conversion so that a second start lands while busy.
  always @(posedge mclk) begin
    conv_done <= (conv_wait == 1);
    cal_step_done <= (step_wait == 1);
    if (conv_wait > 0) conv_wait <= conv_wait - 1;
    if (step_wait > 0) step_wait <= step_wait - 1;
    if (conv_start === 1'b1) begin
      n_conv++;
      conv_wait <= 150;
    end
    if (cal_step_req === 1'b1) begin
      steps.push_back(cal_step);
      step_wait <= 6;
    end
    if (test_write === 1'b1) n_test++;
    if (cal_reg_write === 1'b1) n_calw++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [15:0] w);
    host.send(w, 16);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask : wr

  task automatic wait_idle();
    for (int k = 0; k < 400; k++) begin
      if (busy === 1'b0) return;
      @(negedge mclk);
    end
    mismatches++;
    print_verdict();
  endtask : wait_idle

  initial begin
    logic [13:0] d;
    logic [2:0]  g, o;
    logic [2:0]  e[$];
    mismatches = 0;
    cmp_count = 0;
    n_test = 0;
    n_calw = 0;
    n_conv = 0;
    conv_wait = 0;
    step_wait = 0;
    rstn = 1'b0;
    clk_en = 1'b1;
    read_cycle_done = 1'b0;
    sleep_n_pin = 1'b1;
    conv_done = 1'b0;
    cal_step_done = 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check({input_pairing_select, pos_input_index, neg_input_index, power_mgmt,
           read_target, interface_mode1, busy}, 16'h0040);
    @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 16; i++) begin
      d = {i[3:0], i[1:0], ~i[1:0], 3'h4, i[1:0], 1'b0};
      wr({2'h3, d});
      check({input_pairing_select, pos_input_index, neg_input_index}, ROWS[i]);
      check(power_mgmt, d[9:8]);
      check(read_target, d[7:6]);
      check({interface_mode1, din_drive_allowed}, 2'h3);
      check(cal_reg_addr, d[2:1]);
      check(write_data, d);
      check(status_word, {2'h0, d[13:8], 2'h3, d[5], 1'b0, d[3:0]});
    end
    @(posedge mclk);
    read_cycle_done <= 1'b1;
    @(posedge mclk);
    read_cycle_done <= 1'b0;
    @(negedge mclk);
    check(interface_mode1, 1'b0);
    check(read_target, d[7:6]);
    for (int a = 0; a < 3; a++) begin
      wr({a[1:0], 14'h2AAA});
      check({input_pairing_select, pos_input_index, neg_input_index}, 8'hF8);
      check(n_test, 16'(a > 0));
      check(n_calw, 16'(a == 2));
    end
    host.send({2'h3, 14'h0000}, 8);
    wr({2'h3, 14'h2000});
    check({input_pairing_select, pos_input_index, neg_input_index}, 8'h88);
    @(posedge mclk);
    sleep_n_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check(power_mode_select, 3'h4);
    @(posedge mclk);
    sleep_n_pin <= 1'b1;
    wr({2'h3, 14'h2030});
    check(busy, 1'b1);
    check(n_conv, 16'h0001);
    wr({2'h3, 14'h2030});
    check(n_conv, 16'h0001);
    wait_idle();
    check(busy, 1'b0);
    for (int k = 0; k < 8; k++) begin
      steps.delete();
      e.delete();
      wr({2'h3, 8'h80, 2'h2, k[2:0], 1'b1});
      check(busy, 1'b1);
      check(cal_reg_addr, 2'h0);
      wait_idle();
      g = k[2] ? adc_cfg_pkg::STEP_SYS_GAIN : adc_cfg_pkg::STEP_INT_GAIN;
      o = k[2] ? adc_cfg_pkg::STEP_SYS_OFFSET : adc_cfg_pkg::STEP_INT_OFFSET;
      if (k[1:0] == 2'h0) e.push_back(adc_cfg_pkg::STEP_DAC);
      if (k[1:0] != 2'h2) e.push_back(g);
      if (k[1:0] != 2'h3) e.push_back(o);
      check(steps.size(), e.size());
      foreach (e[j]) check(steps[j], e[j]);
      check(cal_step, adc_cfg_pkg::STEP_NONE);
    end
    print_verdict();
  end
endmodule : adc_control_register_decode_bench
